// ---- verilog/irq_pkg.sv ----
// constants and types shared by the interrupt control block
package irq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PC_W = 15;
  localparam int CTX_BYTES = 9;
  localparam int CTX_IDX_W = 4;

  localparam logic [ADDR_W-1:0] OFS_INTERRUPT_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PERIPHERAL_ENABLE_GROUP0 = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_PERIPHERAL_FLAG_GROUP0 = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATE = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_SHADOW_BASE = 8'h10;

  localparam int CTX_WORK = 0;
  localparam int CTX_STATUS = 1;
  localparam int CTX_BANK = 2;
  localparam int CTX_PTR0_LO = 3;
  localparam int CTX_PTR0_HI = 4;
  localparam int CTX_PTR1_LO = 5;
  localparam int CTX_PTR1_HI = 6;
  localparam int CTX_PC_HIGH = 7;
  localparam int CTX_SPARE = 8;

  localparam int GIE_BIT = 7;
  localparam int PERIPHERAL_GROUP_IRQ_ENABLE_BIT = 6;
  localparam int EDGE_BIT = 0;
  localparam int TMR0_BIT = 5;
  localparam int IOC_BIT = 4;
  localparam int EXT_BIT = 0;
  localparam int TIMEOUT_BIT = 4;
  localparam int POWERDOWN_BIT = 3;

  localparam logic [DATA_W-1:0] INTERRUPT_CONTROL_RESET = 8'h01;
  localparam logic [DATA_W-1:0] STATUS_SAVE_MASK = 8'hE7;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 15'h0004;

  typedef enum logic [2:0] {
    SEQ_RUN,
    SEQ_FLUSH,
    SEQ_PUSH,
    SEQ_VECTOR,
    SEQ_WAKE_STEP
  } seq_state_t;
endpackage : irq_pkg

// ---- verilog/ext_pin_edge.sv ----
// external interrupt pin synchroniser and edge selector
`timescale 1ns/1ps
`default_nettype none
module ext_pin_edge
  import irq_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic pin,
  input wire logic rising_sel,
  output logic edge_seen
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } edge_state_t;

  edge_state_t st;
  edge_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.prev = st.s2;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // only s2 and prev are compared; s1 may be metastable
  assign edge_seen = rising_sel ? (st.s2 & ~st.prev) : (~st.s2 & st.prev);
endmodule : ext_pin_edge
`default_nettype wire

// ---- verilog/context_shadow.sv ----
// shadow copies of the saved core context
`timescale 1ns/1ps
`default_nettype none
module context_shadow
  import irq_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic save,
  input wire logic [CTX_BYTES*DATA_W-1:0] live_ctx,
  input wire logic wr,
  input wire logic [CTX_IDX_W-1:0] wr_idx,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [CTX_BYTES*DATA_W-1:0] shadow_ctx
);
  typedef struct packed {
    logic [CTX_BYTES-1:0][DATA_W-1:0] b;
  } shadow_state_t;

  shadow_state_t st;
  shadow_state_t next_st;

  always_comb begin
    next_st = st;
    if (save) begin
      next_st.b = live_ctx;
      // timeout and powerdown are never captured
      next_st.b[CTX_STATUS] = live_ctx[CTX_STATUS*DATA_W +: DATA_W] & STATUS_SAVE_MASK;
    end else if (wr && (32'(wr_idx) < CTX_BYTES)) begin
      next_st.b[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign shadow_ctx = st.b;
endmodule : context_shadow
`default_nettype wire

// ---- verilog/cpu_interrupt_control.sv ----
// interrupt gating, entry and return sequencing for the core
//
// Contract
// - any reset leaves interrupts disabled
// - vector needs global and source enables, plus the group enable outside group zero
// - flags set regardless of any enable
// - entry: flush, clear global, push, save, vector
// - in service, events flag but never vector
// - return pops, restores context, sets global enable
// - flags pending while disabled vector later
// - latency three to five instruction cycles
// - pin flag may set in any phase
// - wake only for clockless sources already enabled
// - wake vectors if global enabled, else continue
// - instruction after sleep always runs first
// - pin edge chosen by edge select bit
// - valid pin edge sets flag, may vector
// - context copied to shadows, restored on return
// - shadows readable and writable by software
// - group zero sources skip the group enable
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_control
  import irq_pkg::*;
#(
  parameter int PERIPH_N = 8,
  parameter logic [PERIPH_N-1:0] PERIPH_SLEEP_CAPABLE = '0
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic ext_pin,
  input wire logic tmr0_event,
  input wire logic ioc_flag,
  input wire logic [PERIPH_N-1:0] periph_pending,
  input wire logic instr_tick,
  input wire logic sleep_active,
  input wire logic return_from_interrupt,
  input wire logic [CTX_BYTES*DATA_W-1:0] live_ctx,
  output logic prefetch_flush,
  output logic stack_push,
  output logic stack_pop,
  output logic pc_load,
  output logic [PC_W-1:0] pc_load_value,
  output logic ctx_restore,
  output logic [CTX_BYTES*DATA_W-1:0] restore_ctx,
  output logic wake
);
  typedef struct packed {
    seq_state_t seq;
    logic global_irq_enable;
    logic peripheral_group_irq_enable;
    logic ext_pin_edge_select;
    logic tmr0_enable;
    logic ioc_enable;
    logic ext_pin_enable;
    logic tmr0_flag;
    logic ext_pin_irq_flag;
    logic [DATA_W-1:0] rdata;
    logic flush;
    logic push;
    logic save;
    logic pop;
    logic restore;
    logic load;
    logic [PC_W-1:0] load_value;
    logic wake;
    logic [CTX_BYTES*DATA_W-1:0] restore_data;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;

  logic ext_edge;
  logic [CTX_BYTES*DATA_W-1:0] shadow_ctx;
  logic shadow_wr;
  logic [CTX_IDX_W-1:0] shadow_idx;
  logic [ADDR_W-1:0] shadow_off;
  logic group0_pending;
  logic group_pending;
  logic vector_request;
  logic wake_source;
  logic [DATA_W-1:0] status_live;
  logic [DATA_W-1:0] status_saved;

  ext_pin_edge u_ext_pin_edge (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .pin(ext_pin),
    .rising_sel(st.ext_pin_edge_select),
    .edge_seen(ext_edge)
  );

  context_shadow u_context_shadow (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .save(st.save),
    .live_ctx(live_ctx),
    .wr(shadow_wr),
    .wr_idx(shadow_idx),
    .wr_data(reg_wdata),
    .shadow_ctx(shadow_ctx)
  );

  // shadow window sits above the control registers
  assign shadow_off = reg_addr - OFS_SHADOW_BASE;
  assign shadow_idx = shadow_off[CTX_IDX_W-1:0];
  assign shadow_wr = reg_wr && (reg_addr >= OFS_SHADOW_BASE)
    && (32'(shadow_off) < CTX_BYTES);

  // group zero sources need no group enable
  assign group0_pending = (st.tmr0_enable & st.tmr0_flag)
    | (st.ioc_enable & ioc_flag)
    | (st.ext_pin_enable & st.ext_pin_irq_flag);
  assign group_pending = st.peripheral_group_irq_enable & (|periph_pending);
  // level based, so a flag left set while disabled vectors once enabled
  assign vector_request = st.global_irq_enable & (group0_pending | group_pending);

  // timer zero stops without its clock, so it never wakes the core
  assign wake_source = (st.ioc_enable & ioc_flag)
    | (st.ext_pin_enable & st.ext_pin_irq_flag)
    | (st.peripheral_group_irq_enable
       & (|(periph_pending & PERIPH_SLEEP_CAPABLE)));

  assign status_live = live_ctx[CTX_STATUS*DATA_W +: DATA_W];
  assign status_saved = shadow_ctx[CTX_STATUS*DATA_W +: DATA_W];

  always_comb begin
    next_st = st;
    next_st.flush = 1'b0;
    next_st.push = 1'b0;
    next_st.save = 1'b0;
    next_st.pop = 1'b0;
    next_st.restore = 1'b0;
    next_st.load = 1'b0;
    next_st.wake = 1'b0;
    next_st.rdata = '0;

    // software writes first; hardware actions below take priority
    if (reg_wr) begin
      if (reg_addr == OFS_INTERRUPT_CONTROL) begin
        next_st.global_irq_enable = reg_wdata[GIE_BIT];
        next_st.peripheral_group_irq_enable = reg_wdata[PERIPHERAL_GROUP_IRQ_ENABLE_BIT];
        next_st.ext_pin_edge_select = reg_wdata[EDGE_BIT];
      end else if (reg_addr == OFS_PERIPHERAL_ENABLE_GROUP0) begin
        next_st.tmr0_enable = reg_wdata[TMR0_BIT];
        next_st.ioc_enable = reg_wdata[IOC_BIT];
        next_st.ext_pin_enable = reg_wdata[EXT_BIT];
      end else if (reg_addr == OFS_PERIPHERAL_FLAG_GROUP0) begin
        next_st.tmr0_flag = reg_wdata[TMR0_BIT];
        next_st.ext_pin_irq_flag = reg_wdata[EXT_BIT];
      end
    end

    // set beats a clear in the same cycle
    if (tmr0_event) begin
      next_st.tmr0_flag = 1'b1;
    end
    // caught on any clock edge, not tied to a phase
    if (ext_edge) begin
      next_st.ext_pin_irq_flag = 1'b1;
    end

    case (st.seq)
      SEQ_RUN: begin
        if (sleep_active) begin
          if (wake_source) begin
            next_st.wake = 1'b1;
            next_st.seq = SEQ_WAKE_STEP;
          end
        end else if (instr_tick && return_from_interrupt) begin
          next_st.pop = 1'b1;
          next_st.restore = 1'b1;
          next_st.restore_data = shadow_ctx;
          // live timeout and powerdown survive the restore
          next_st.restore_data[CTX_STATUS*DATA_W +: DATA_W] =
            (status_saved & STATUS_SAVE_MASK) | (status_live & ~STATUS_SAVE_MASK);
          next_st.global_irq_enable = 1'b1;
        end else if (instr_tick && vector_request) begin
          next_st.seq = SEQ_FLUSH;
        end
      end
      SEQ_FLUSH: begin
        if (instr_tick) begin
          next_st.flush = 1'b1;
          // cleared here, so further events only flag
          next_st.global_irq_enable = 1'b0;
          next_st.seq = SEQ_PUSH;
        end
      end
      SEQ_PUSH: begin
        if (instr_tick) begin
          next_st.push = 1'b1;
          next_st.save = 1'b1;
          next_st.seq = SEQ_VECTOR;
        end
      end
      SEQ_VECTOR: begin
        if (instr_tick) begin
          next_st.load = 1'b1;
          next_st.load_value = IRQ_VECTOR;
          next_st.seq = SEQ_RUN;
        end
      end
      SEQ_WAKE_STEP: begin
        // one full instruction after sleep before any vectoring
        if (instr_tick && !sleep_active) begin
          next_st.seq = SEQ_RUN;
        end
      end
      default: begin
        next_st.seq = SEQ_RUN;
      end
    endcase

    if (reg_rd) begin
      if (reg_addr == OFS_INTERRUPT_CONTROL) begin
        next_st.rdata[GIE_BIT] = st.global_irq_enable;
        next_st.rdata[PERIPHERAL_GROUP_IRQ_ENABLE_BIT] = st.peripheral_group_irq_enable;
        next_st.rdata[EDGE_BIT] = st.ext_pin_edge_select;
      end else if (reg_addr == OFS_PERIPHERAL_ENABLE_GROUP0) begin
        next_st.rdata[TMR0_BIT] = st.tmr0_enable;
        next_st.rdata[IOC_BIT] = st.ioc_enable;
        next_st.rdata[EXT_BIT] = st.ext_pin_enable;
      end else if (reg_addr == OFS_PERIPHERAL_FLAG_GROUP0) begin
        next_st.rdata[TMR0_BIT] = st.tmr0_flag;
        next_st.rdata[IOC_BIT] = ioc_flag;
        next_st.rdata[EXT_BIT] = st.ext_pin_irq_flag;
      end else if (reg_addr == OFS_IRQ_STATE) begin
        next_st.rdata[0] = vector_request;
        next_st.rdata[1] = (st.seq != SEQ_RUN);
        next_st.rdata[2] = wake_source;
        next_st.rdata[3] = group_pending;
      end else if (shadow_wr || ((reg_addr >= OFS_SHADOW_BASE)
          && (32'(shadow_off) < CTX_BYTES))) begin
        next_st.rdata = shadow_ctx[shadow_idx*DATA_W +: DATA_W];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.seq <= SEQ_RUN;
      st.ext_pin_edge_select <= INTERRUPT_CONTROL_RESET[EDGE_BIT];
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign prefetch_flush = st.flush;
  assign stack_push = st.push;
  assign stack_pop = st.pop;
  assign pc_load = st.load;
  assign pc_load_value = st.load_value;
  assign ctx_restore = st.restore;
  assign restore_ctx = st.restore_data;
  assign wake = st.wake;
endmodule : cpu_interrupt_control
`default_nettype wire

// ---- testbench/cpu_interrupt_control_chk.sv ----
// assertions on the interrupt control ports
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_control_chk
  import irq_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic sleep_active,
  input wire logic [CTX_BYTES*DATA_W-1:0] live_ctx,
  input wire logic prefetch_flush,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_load_value,
  input wire logic ctx_restore,
  input wire logic [CTX_BYTES*DATA_W-1:0] restore_ctx,
  input wire logic wake
);
  logic gie_m;
  logic [7:0] live_st;
  assign live_st = live_ctx[15:8];
  // global enable as software and sequencing leave it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) gie_m <= 1'b0;
    else if (stack_pop) gie_m <= 1'b1;
    else if (prefetch_flush) gie_m <= 1'b0;
    else if (reg_wr && reg_addr == OFS_INTERRUPT_CONTROL) gie_m <= reg_wdata[7];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_vector_gated: assert property ($rose(prefetch_flush) |-> gie_m)
    else $error("entry started with global enable clear");
  a_entry_order: assert property ($rose(prefetch_flush) |-> ##[1:12] stack_push ##[1:12] pc_load)
    else $error("entry steps out of order");
  a_vector_addr: assert property (pc_load |-> pc_load_value == IRQ_VECTOR)
    else $error("pc load not at vector");
  a_flush_pulse: assert property (prefetch_flush |=> !prefetch_flush)
    else $error("flush longer than one cycle");
  a_pop_restore: assert property (stack_pop |-> ctx_restore && !prefetch_flush)
    else $error("pop without context restore");
  a_status_keep: assert property (ctx_restore |->
    (restore_ctx[15:8] & 8'h18) == ($past(live_st) & 8'h18))
    else $error("timeout or powerdown bit restored from shadow");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_ctrl_unused: assert property ($past(reg_rd) && $past(reg_addr) == OFS_INTERRUPT_CONTROL
    |-> reg_rdata[5:1] == 5'h00)
    else $error("control unused bits not zero");
  a_wake_asleep: assert property (wake |-> $past(sleep_active))
    else $error("wake while not asleep");
  a_wake_pulse: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  c_entry: cover property ($rose(prefetch_flush));
  c_return: cover property (stack_pop);
  c_wake: cover property (wake);
endmodule : cpu_interrupt_control_chk

bind cpu_interrupt_control cpu_interrupt_control_chk u_chk (.clk, .reset, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_active, .live_ctx, .prefetch_flush,
  .stack_push, .stack_pop, .pc_load, .pc_load_value, .ctx_restore, .restore_ctx, .wake);
`default_nettype wire

// ---- testbench/core_seq_model.sv ----
// core sequencer stand-in: instruction ticks and return decode
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic ret_req,
  input wire logic slow,
  output logic instr_tick,
  output logic return_from_interrupt
);
  logic [2:0] q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) q <= 3'h0;
    else q <= q + 3'h1;
  end
  // slow mode doubles the instruction cycle
  assign instr_tick = slow ? (q == 3'h7) : (q[1:0] == 2'h3);
  // return is decoded only on a boundary
  assign return_from_interrupt = ret_req && instr_tick;
endmodule : core_seq_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the interrupt control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import irq_pkg::*;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, ext_pin = 0, tmr0_event = 0;
  logic sleep_active = 0, ret_req = 0, slow = 0, instr_tick, return_from_interrupt;
  logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, periph_pending = '0, rv, sv;
  logic [71:0] live_ctx = '0, restore_ctx;
  logic [14:0] pc_load_value;
  logic prefetch_flush, stack_push, stack_pop, pc_load, ctx_restore, wake;
  int failures = 0, n_tests = 0, n_flush = 0, n_wake = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    n_flush += prefetch_flush;
    n_wake += wake;
  end
  cpu_interrupt_control u_cpu_interrupt_control (.clk, .reset, .ce(1'b1), .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_pin, .tmr0_event, .ioc_flag(1'b0),
    .periph_pending, .instr_tick, .sleep_active, .return_from_interrupt, .live_ctx,
    .prefetch_flush, .stack_push, .stack_pop, .pc_load, .pc_load_value, .ctx_restore,
    .restore_ctx, .wake);
  core_seq_model u_core_seq_model (.clk, .reset, .ret_req, .slow, .instr_tick,
    .return_from_interrupt);
  task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  task automatic pin(input logic v);
    @(posedge clk);
    ext_pin <= v;
    cyc(6);
  endtask : pin
  task automatic tmr_pulse;
    @(posedge clk);
    tmr0_event <= 1'b1;
    @(posedge clk);
    tmr0_event <= 1'b0;
  endtask : tmr_pulse
  // return is held only up to the boundary that takes it, else it pops twice
  task automatic ret_irq;
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk iff instr_tick);
    ret_req <= 1'b0;
    cyc(2);
  endtask : ret_irq
  function automatic logic [7:0] exp_sh(input int k);
    return live_ctx[8*k +: 8] & ((k == 1) ? 8'hE7 : 8'hFF);
  endfunction : exp_sh
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    #50000;
    failures++;
    give_verdict();
  end
  initial begin
    void'($urandom(6));
    cyc(5);
    reset <= 1'b0;
    rd(OFS_INTERRUPT_CONTROL); chk("ctrl reset", 72'h01, rv);
    wr(OFS_INTERRUPT_CONTROL, 8'hFF);
    rd(OFS_INTERRUPT_CONTROL); chk("ctrl layout", 72'hC1, rv);
    wr(OFS_INTERRUPT_CONTROL, 8'h01);
    rd(8'h40); chk("unmapped", 72'h00, rv);
    tmr_pulse();
    rd(OFS_PERIPHERAL_FLAG_GROUP0); chk("flag no enable", 72'h20, rv & 8'h20);
    wr(OFS_PERIPHERAL_ENABLE_GROUP0, 8'h20);
    live_ctx <= {8'h00, $urandom, $urandom};
    cyc(30); chk("no entry gie off", 72'd0, n_flush);
    wr(OFS_INTERRUPT_CONTROL, 8'h81);
    cyc(30); chk("pending serviced", 72'd1, n_flush);
    rd(OFS_INTERRUPT_CONTROL); chk("gie cleared", 72'h01, rv);
    tmr_pulse();
    cyc(30); chk("no nesting", 72'd1, n_flush);
    for (int k = 0; k < 8; k++) begin
      rd(OFS_SHADOW_BASE + 8'(k)); chk("shadow", exp_sh(k), rv);
    end
    sv = 8'($urandom);
    wr(OFS_SHADOW_BASE, sv);
    wr(OFS_PERIPHERAL_FLAG_GROUP0, 8'h00);
    live_ctx[7:0] <= ~sv;
    ret_irq();
    chk("shadow restored", sv, restore_ctx[7:0]);
    rd(OFS_INTERRUPT_CONTROL); chk("gie set", 72'h81, rv);
    slow <= 1'b1;
    wr(OFS_PERIPHERAL_ENABLE_GROUP0, 8'h00);
    periph_pending <= 8'h01;
    cyc(40); chk("group gated", 72'd1, n_flush);
    wr(OFS_INTERRUPT_CONTROL, 8'hC1);
    cyc(60); chk("group entry", 72'd2, n_flush);
    periph_pending <= 8'h00;
    ret_irq();
    slow <= 1'b0;
    wr(OFS_INTERRUPT_CONTROL, 8'h01);
    for (int s = 0; s < 2; s++) begin
      wr(OFS_INTERRUPT_CONTROL, {7'h00, s[0]});
      pin(~s[0]);
      wr(OFS_PERIPHERAL_FLAG_GROUP0, 8'h00);
      pin(s[0]);
      rd(OFS_PERIPHERAL_FLAG_GROUP0); chk("pin valid edge", 72'h01, rv & 8'h01);
      wr(OFS_PERIPHERAL_FLAG_GROUP0, 8'h00);
      pin(~s[0]);
      rd(OFS_PERIPHERAL_FLAG_GROUP0); chk("pin other edge", 72'h00, rv & 8'h01);
    end
    wr(OFS_INTERRUPT_CONTROL, 8'h01);
    wr(OFS_PERIPHERAL_ENABLE_GROUP0, 8'h01);
    wr(OFS_PERIPHERAL_FLAG_GROUP0, 8'h00);
    sleep_active <= 1'b1;
    pin(1'b1);
    chk("wake", 72'd1, n_wake);
    sleep_active <= 1'b0;
    cyc(40); chk("wake no vector", 72'd2, n_flush);
    pin(1'b0);
    wr(OFS_PERIPHERAL_FLAG_GROUP0, 8'h00);
    wr(OFS_INTERRUPT_CONTROL, 8'h81);
    sleep_active <= 1'b1;
    pin(1'b1);
    chk("wake gie", 72'd2, n_wake);
    chk("no vector asleep", 72'd2, n_flush);
    sleep_active <= 1'b0;
    cyc(40); chk("wake vector", 72'd3, n_flush);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
